// *** core/uevp_pkg.sv ***
// Package with register map, field layout and reset values of the event and publish block
package uevp_pkg;
  localparam int          UEVP_ADDR_W         = 12;
  localparam logic [11:0] UEVP_OFF_TX_BYTE    = 12'h11c;
  localparam logic [11:0] UEVP_OFF_TX_DONE    = 12'h120;
  localparam logic [11:0] UEVP_OFF_ERROR      = 12'h124;
  localparam logic [11:0] UEVP_OFF_RX_TMO     = 12'h144;
  localparam logic [11:0] UEVP_OFF_RX_BEGUN   = 12'h14c;
  localparam logic [11:0] UEVP_OFF_TX_BEGUN   = 12'h150;
  localparam logic [11:0] UEVP_OFF_TX_HALTED  = 12'h158;
  localparam logic [11:0] UEVP_OFF_CTS_ROUTE  = 12'h180;
  localparam int          UEVP_NUM_FLAGS      = 7;
  localparam int          UEVP_CHANNEL_INDEX_W        = 4;
  localparam int          UEVP_CHANNEL_INDEX_LSB      = 0;
  localparam int          UEVP_EN_BIT         = 31;
  localparam int          UEVP_NUM_CH         = 16;
  localparam logic [31:0] UEVP_FLAG_RESET     = 32'h0000_0000;
  localparam logic [31:0] UEVP_ROUTE_RESET    = 32'h0000_0000;
  localparam logic        UEVP_CTS_ACTIVE_LVL = 1'b0;
  // Flag slot order inside the flag vector
  localparam int UEVP_F_TX_BYTE   = 0;
  localparam int UEVP_F_TX_DONE   = 1;
  localparam int UEVP_F_ERROR     = 2;
  localparam int UEVP_F_RX_TMO    = 3;
  localparam int UEVP_F_RX_BEGUN  = 4;
  localparam int UEVP_F_TX_BEGUN  = 5;
  localparam int UEVP_F_TX_HALTED = 6;

  // Map an offset to its flag slot; returns UEVP_NUM_FLAGS for no flag
  function automatic int uevp_flag_slot(input logic [11:0] off);
    unique case (off)
      UEVP_OFF_TX_BYTE:   return UEVP_F_TX_BYTE;
      UEVP_OFF_TX_DONE:   return UEVP_F_TX_DONE;
      UEVP_OFF_ERROR:     return UEVP_F_ERROR;
      UEVP_OFF_RX_TMO:    return UEVP_F_RX_TMO;
      UEVP_OFF_RX_BEGUN:  return UEVP_F_RX_BEGUN;
      UEVP_OFF_TX_BEGUN:  return UEVP_F_TX_BEGUN;
      UEVP_OFF_TX_HALTED: return UEVP_F_TX_HALTED;
      default:            return UEVP_NUM_FLAGS;
    endcase
  endfunction
endpackage

// *** core/uevp_evt_if.sv ***
// Interface carrying event pulses and flag clear strobes between the top and the flag bank
`timescale 1ns/1ns
`default_nettype none
interface uevp_evt_if #(parameter int N = 7);
  logic [N-1:0] set_pulse;
  logic [N-1:0] clr_strobe;
  logic [N-1:0] flag;
  modport bank (input set_pulse, input clr_strobe, output flag);
  modport ctl  (output set_pulse, output clr_strobe, input flag);
endinterface
`default_nettype wire

// *** core/uevp_flag_bank.sv ***
// Bank of sticky event flags, set by hardware and cleared by software
`timescale 1ns/1ns
`default_nettype none
module uevp_flag_bank
  import uevp_pkg::*;
#(
  parameter int N = UEVP_NUM_FLAGS
) (
  input  wire logic   core_clk_i,
  input  wire logic   resetn_i,
  uevp_evt_if.bank    evt
);
  typedef struct packed {
    logic [N-1:0] flag;
  } uevp_bank_state_type;

  uevp_bank_state_type st_r;
  uevp_bank_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++) begin
      // Set beats clear so an event landing on the clear write is kept
      if (evt.set_pulse[i]) begin
        st_nxt.flag[i] = 1'b1;
      end else if (evt.clr_strobe[i]) begin
        st_nxt.flag[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt.flag = st_r.flag;
endmodule
`default_nettype wire

// *** core/uevp_cts_router.sv ***
// Clear-to-send edge detector and publish router onto interconnect channels
`timescale 1ns/1ns
`default_nettype none
module uevp_cts_router
  import uevp_pkg::*;
#(
  parameter int NCH = UEVP_NUM_CH
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    cts_i,
  input  wire logic                    route_en_i,
  input  wire logic [UEVP_CHANNEL_INDEX_W-1:0] route_channel_index_i,
  output logic                         cts_event_o,
  output logic [NCH-1:0]               channel_o
);
  typedef struct packed {
    logic           cts_prev;
    logic           evt;
    logic [NCH-1:0] ch;
  } uevp_rt_state_type;

  uevp_rt_state_type st_r;
  uevp_rt_state_type st_nxt;
  logic              fall;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.cts_prev = cts_i;
    // Event on the line going to its active low level
    fall            = (cts_i == UEVP_CTS_ACTIVE_LVL) && (st_r.cts_prev != UEVP_CTS_ACTIVE_LVL);
    st_nxt.evt      = fall;
    st_nxt.ch       = '0;
    if (fall && route_en_i) begin
      st_nxt.ch[route_channel_index_i] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      // Idle level high keeps a reset release from faking an event
      st_r <= '{cts_prev: 1'b1, evt: 1'b0, ch: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cts_event_o = st_r.evt;
  assign channel_o   = st_r.ch;
endmodule
`default_nettype wire

// *** core/uevp_top.sv ***
// Event flag and clear-to-send publish registers of the serial port, APB slave
// Function
// - Transmit-done flag sets when the last buffer byte has left the line.
// - Receiver-started flag sets when reception actually begins.
// - Transmitter-started flag sets when transmission actually begins.
// - Publish enable bit gates forwarding of clear-to-send events.
// - Forwarded events go to the channel indexed by low field; reset zero.
// - Clear-to-send event is raised when the remote pulls the line low.
`timescale 1ns/1ns
`default_nettype none
module uevp_top
  import uevp_pkg::*;
#(
  parameter int NCH = UEVP_NUM_CH
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [UEVP_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic                   tx_byte_sent_i,
  input  wire logic                   tx_buffer_done_i,
  input  wire logic                   error_i,
  input  wire logic                   rx_timeout_i,
  input  wire logic                   rx_begun_i,
  input  wire logic                   tx_begun_i,
  input  wire logic                   tx_halted_i,
  input  wire logic                   cts_i,
  output logic                        cts_event_o,
  output logic      [NCH-1:0]         channel_o
);
  typedef struct packed {
    logic [31:0] route;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } uevp_top_state_type;

  uevp_top_state_type st_r;
  uevp_top_state_type st_nxt;

  uevp_evt_if #(.N(UEVP_NUM_FLAGS)) evt ();

  logic acc;
  logic wr_acc;
  int   slot;

  // Events from the data path, one cycle pulses
  always_comb begin
    evt.set_pulse                   = '0;
    evt.set_pulse[UEVP_F_TX_BYTE]   = tx_byte_sent_i;
    evt.set_pulse[UEVP_F_TX_DONE]   = tx_buffer_done_i;
    evt.set_pulse[UEVP_F_ERROR]     = error_i;
    evt.set_pulse[UEVP_F_RX_TMO]    = rx_timeout_i;
    evt.set_pulse[UEVP_F_RX_BEGUN]  = rx_begun_i;
    evt.set_pulse[UEVP_F_TX_BEGUN]  = tx_begun_i;
    evt.set_pulse[UEVP_F_TX_HALTED] = tx_halted_i;
  end

  // Transfer is taken in the first access cycle; ready is a registered pulse one cycle later,
  // so acc is gated by ready low to take each transfer exactly once
  assign acc    = psel_i && penable_i && !st_r.ready;
  assign wr_acc = acc && pwrite_i;
  assign slot   = uevp_flag_slot(paddr_i);

  always_comb begin
    evt.clr_strobe = '0;
    // Writing 0 clears; writing 1 is ignored so software cannot fake an event
    if (wr_acc && slot < UEVP_NUM_FLAGS && !pwdata_i[0]) begin
      evt.clr_strobe[slot] = 1'b1;
    end
  end

  always_comb begin
    st_nxt       = st_r;
    st_nxt.ready = acc;
    st_nxt.err   = 1'b0;
    st_nxt.rdata = '0;
    if (acc) begin
      if (slot < UEVP_NUM_FLAGS) begin
        st_nxt.rdata = {31'h0000_0000, evt.flag[slot]};
      end else if (paddr_i == UEVP_OFF_CTS_ROUTE) begin
        if (pwrite_i) begin
          // Only the enable bit and channel index field are kept
          st_nxt.route                 = '0;
          st_nxt.route[UEVP_EN_BIT]    = pwdata_i[UEVP_EN_BIT];
          st_nxt.route[UEVP_CHANNEL_INDEX_W-1:UEVP_CHANNEL_INDEX_LSB] =
            pwdata_i[UEVP_CHANNEL_INDEX_W-1:UEVP_CHANNEL_INDEX_LSB];
        end
        st_nxt.rdata = st_r.route;
      end else begin
        st_nxt.err = 1'b1;
      end
      if (pwrite_i) begin
        st_nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_r <= '{route: UEVP_ROUTE_RESET, rdata: UEVP_FLAG_RESET, ready: 1'b0, err: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  uevp_flag_bank #(.N(UEVP_NUM_FLAGS)) u_flags (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .evt        (evt.bank)
  );

  uevp_cts_router #(.NCH(NCH)) u_cts (
    .core_clk_i    (core_clk_i),
    .resetn_i      (resetn_i),
    .cts_i         (cts_i),
    .route_en_i    (st_r.route[UEVP_EN_BIT]),
    .route_channel_index_i (st_r.route[UEVP_CHANNEL_INDEX_W-1:UEVP_CHANNEL_INDEX_LSB]),
    .cts_event_o   (cts_event_o),
    .channel_o     (channel_o)
  );

  assign prdata_o  = st_r.rdata;
  assign pready_o  = st_r.ready;
  assign pslverr_o = st_r.err;
endmodule
`default_nettype wire

// *** verification/uevp_top_assertions.sv ***
// Concurrent checks on the ports of the event publish block
`timescale 1ns/1ns
`default_nettype none
module uevp_top_assertions
  import uevp_pkg::*;
#(parameter int NCH = UEVP_NUM_CH) (
  input wire logic                   core_clk_i,
  input wire logic                   resetn_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [UEVP_ADDR_W-1:0] paddr_i,
  input wire logic [31:0]            prdata_o,
  input wire logic                   pready_o,
  input wire logic                   tx_buffer_done_i,
  input wire logic                   rx_begun_i,
  input wire logic                   tx_begun_i,
  input wire logic                   cts_i,
  input wire logic                   cts_event_o,
  input wire logic [NCH-1:0]         channel_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic acc = psel_i && penable_i && !pready_o;
  // A read taken one edge after the event must already see the flag
  property p_flag(ev, logic [11:0] off);
    ev ##1 (acc && !pwrite_i && paddr_i == off) |=> prdata_o[0];
  endproperty
  a_done_flag: assert property (p_flag(tx_buffer_done_i, UEVP_OFF_TX_DONE))
    else $error("done flag not seen");
  a_rx_begun: assert property (p_flag(rx_begun_i, UEVP_OFF_RX_BEGUN))
    else $error("rx begun flag not seen");
  a_tx_begun: assert property (p_flag(tx_begun_i, UEVP_OFF_TX_BEGUN))
    else $error("tx begun flag not seen");
  a_access_ready: assert property (acc |=> pready_o ##1 !pready_o)
    else $error("ready pulse wrong");
  a_cts_fall: assert property ($fell(cts_i) |=> cts_event_o)
    else $error("cts fall missed");
  a_cts_cause: assert property (cts_event_o |-> $past(cts_i, 2) && !$past(cts_i))
    else $error("cts event without fall");
  a_route_gated: assert property (channel_o != '0 |-> cts_event_o)
    else $error("channel without event");
  a_route_onehot: assert property (channel_o != '0 |-> $onehot(channel_o))
    else $error("channel not one-hot");
  c_routed: cover property (cts_event_o && channel_o != '0);
  c_unrouted: cover property (cts_event_o && channel_o == '0);
  c_flag_read: cover property (pready_o && prdata_o[0]);
endmodule
`default_nettype wire

// *** verification/uevp_remote_peer.sv ***
// Remote serial peer that grants permission to send
`timescale 1ns/1ns
`default_nettype none
module uevp_remote_peer (
  input  wire logic clk_i,
  output logic      cts_o
);
  initial cts_o = 1'b1;
  // Permission is a low level; the line rests high between grants
  task automatic grant(input int hold);
    @(posedge clk_i) cts_o <= 1'b0;
    repeat (hold) @(posedge clk_i);
    cts_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verification/tb_uevp_top.sv ***
// Testbench for the event flag and publish registers
`timescale 1ns/1ns
`default_nettype none
module tb_uevp_top
  import uevp_pkg::*;
;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, e;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, q, prd;
  logic [6:0] evs = 0;
  logic rdy, err, ev_o, cts;
  logic [15:0] ch;
  int n_errors = 0, samples_checked = 0;
  logic [11:0] offs [8] = '{UEVP_OFF_TX_BYTE, UEVP_OFF_TX_DONE, UEVP_OFF_ERROR,
    UEVP_OFF_RX_TMO, UEVP_OFF_RX_BEGUN, UEVP_OFF_TX_BEGUN, UEVP_OFF_TX_HALTED,
    UEVP_OFF_CTS_ROUTE};
  initial forever #4 clk = ~clk;
  uevp_remote_peer peer (.clk_i(clk), .cts_o(cts));
  uevp_top DUT (.core_clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .tx_byte_sent_i(evs[0]), .tx_buffer_done_i(evs[1]),
    .error_i(evs[2]), .rx_timeout_i(evs[3]), .rx_begun_i(evs[4]), .tx_begun_i(evs[5]),
    .tx_halted_i(evs[6]), .cts_i(cts), .cts_event_o(ev_o), .channel_o(ch));
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  // A read shows the flag as it stood before the taking edge, so the pulse is sampled first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [6:0] ev, output logic [31:0] rq, output logic re);
    int n;
    if (ev != 0) begin
      evs <= ev;
      @(posedge clk);
      evs <= 0;
    end
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk) pen <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (rdy !== 1 && n < 20);
    if (n == 20) begin chk(0, 1); summarize; end
    rq = prd;
    re = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic cts_seen(input logic [15:0] x, input int hold);
    int n;
    fork
      peer.grant(hold);
      begin
        n = 0;
        do begin @(posedge clk); n++; end while (ev_o !== 1 && n < 8);
        if (n == 8) begin chk(0, 1); summarize; end
        chk(32'(ch), 32'(x));
      end
    join
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      apb(0, offs[i], 0, 0, q, e); chk(q, 0);
    end
    for (int i = 0; i < 7; i++) begin
      apb(0, offs[i], 0, 7'(1 << i), q, e); chk(q, 1);
      apb(1, offs[i], 1, 0, q, e);
      apb(0, offs[i], 0, 0, q, e); chk(q, 1);
      apb(1, offs[i], 32'hffff_fffe, 0, q, e);
      apb(0, offs[i], 0, 0, q, e); chk(q, 0);
    end
    apb(0, 12'h000, 0, 0, q, e); chk(q, 0);
    chk(32'(e), 1);
    apb(1, UEVP_OFF_CTS_ROUTE, 32'hffff_ffff, 0, q, e);
    apb(0, UEVP_OFF_CTS_ROUTE, 0, 0, q, e); chk(q, 32'h8000_000f);
    for (int c = 0; c < 16; c++) begin
      apb(1, UEVP_OFF_CTS_ROUTE, 32'h8000_0000 | c, 0, q, e);
      cts_seen(16'(1 << c), 1 + c % 3);
    end
    apb(1, UEVP_OFF_CTS_ROUTE, 32'h0000_0003, 0, q, e);
    cts_seen(16'h0000, 2);
    summarize;
  end
endmodule
bind uevp_top uevp_top_assertions #(.NCH(NCH)) u_chk (.*);
`default_nettype wire
